// >>> common/rsc_consts.vh
// Constants for the repetitive set-point counter: register map, fields, timing.
// Assumes inclusion by the design files of the counter; definitions only.
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RSC_ADDR_W        6
`define RSC_OFF_CTRL      6'h00
`define RSC_OFF_STAT_A    6'h04
`define RSC_OFF_STAT_B    6'h08
`define RSC_OFF_ACTUAL    6'h0C
`define RSC_OFF_SP1       6'h10
`define RSC_OFF_SP2       6'h14
`define RSC_OFF_FINAL     6'h18
`define RSC_OFF_WIDTH     6'h1C
`define RSC_OFF_CFG       6'h20

// ****************************************
// Control word fields
// ****************************************
`define RSC_CTRL_LOAD     0
`define RSC_CTRL_RESTART  1
`define RSC_CTRL_KILL     2
`define RSC_MODE_LSB      4
`define RSC_MODE_MSB      7
`define RSC_DIR_LSB       8
`define RSC_DIR_MSB       11
`define RSC_MODE_REPEAT   4'h5
`define RSC_DIR_UP        4'h0

// ****************************************
// Config word fields
// ****************************************
`define RSC_CFG_TYPE_LSB  0
`define RSC_CFG_TYPE_MSB  3
`define RSC_TYPE_RELATIVE 4'h1
`define RSC_CFG_EN_ASSIGN 4
`define RSC_CFG_KILL_ASGN 5
`define RSC_CFG_FALLING   6

// ****************************************
// Status bit positions
// ****************************************
`define RSC_STA_SP1       1
`define RSC_STA_SP2       9
`define RSC_STB_FINAL     9

// ****************************************
// Reset values
// ****************************************
`define RSC_RST_CTRL      16'h0050
`define RSC_RST_CFG       16'h0001
`define RSC_RST_SP1       16'h000B
`define RSC_RST_SP2       16'h0005
`define RSC_RST_FINAL     16'h001E
`define RSC_RST_WIDTH     16'h0014

// ****************************************
// Timing
// ****************************************
`define RSC_TICK_MS       20
`define RSC_CLK_KHZ       25000
`define RSC_TICK_CYCLES   (`RSC_TICK_MS * `RSC_CLK_KHZ)

// ****************************************
// AXI responses
// ****************************************
`define RSC_RESP_OKAY     2'h0
`define RSC_RESP_SLVERR   2'h2

`endif

// >>> hw/rsc_pulse_timer.v
// Timed pulse generator: holds its output for a count of coarse ticks.
// Assumes a one-cycle start pulse and a width count held stable by the caller.
`timescale 1ns/10ps
`include "rsc_consts.vh"

module rsc_pulse_timer #(
  parameter TICK_CYCLES = `RSC_TICK_CYCLES,
  parameter WIDTH_W     = 16
) (
  input  wire               clock,
  input  wire               reset_n,
  input  wire               start,
  input  wire               stop,
  input  wire [WIDTH_W-1:0] width,
  output reg                pulse_q
);

  reg [31:0]        prescale_q;
  reg [WIDTH_W-1:0] ticks_q;
  wire              tick_w;

  assign tick_w = (prescale_q == TICK_CYCLES - 1);

  // ****************************************
  // Prescaler and tick count
  // ****************************************
  // Restart wins over stop, but rsc_top masks start with stop, so a final hit in a stop cycle yields no pulse
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prescale_q <= 32'h00000000;
      ticks_q    <= {WIDTH_W{1'b0}};
      pulse_q    <= 1'b0;
    end
    else if (start)
    begin
      prescale_q <= 32'h00000000;
      ticks_q    <= width;
      pulse_q    <= (width != {WIDTH_W{1'b0}});
    end
    else if (stop)
    begin
      pulse_q    <= 1'b0;
      ticks_q    <= {WIDTH_W{1'b0}};
    end
    else if (pulse_q)
    begin
      prescale_q <= tick_w ? 32'h00000000 : prescale_q + 32'h00000001;
      if (tick_w)
      begin
        ticks_q <= ticks_q - {{(WIDTH_W-1){1'b0}}, 1'b1};
        if (ticks_q == {{(WIDTH_W-1){1'b0}}, 1'b1})
          pulse_q <= 1'b0;
      end
    end
  end

endmodule

// >>> hw/rsc_top.v
// Repetitive set-point counter channel with an AXI4-Lite register slave.
// Assumes inputs synchronous to clock and one AXI master with one write and
// one read outstanding at most.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "rsc_consts.vh"

module rsc_top #(
  parameter TICK_CYCLES = `RSC_TICK_CYCLES,
  parameter CNT_W       = 16
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [5:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [5:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  input  wire        count_pulse_in,
  input  wire        count_enable_in,
  input  wire        load_start_input,
  input  wire        output_kill_input,
  output reg         setpoint_one_output,
  output reg         setpoint_two_output,
  output reg         final_point_output,
  output wire        timed_final_pulse_output
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [15:0]      ctrl_q;
  reg  [15:0]      cfg_q;
  reg  [15:0]      sp1_q;
  reg  [15:0]      sp2_q;
  reg  [15:0]      final_q;
  reg  [15:0]      width_q;
  reg  [CNT_W-1:0] actual_q;
  reg              running_q;
  reg              pulse_in_q;

  // AXI write path state
  reg              aw_got_q;
  reg              w_got_q;
  reg  [5:0]       waddr_q;
  reg  [31:0]      wdata_q;
  reg  [3:0]       wstrb_q;

  wire             wr_fire;
  wire [15:0]      wr_mask;
  wire [15:0]      ctrl_new;
  wire [15:0]      cfg_new;
  wire             wr_ctrl;
  wire             wr_cfg;
  wire             wr_known;
  wire             load_evt;
  wire             kill_now;
  wire             cfg_change;
  wire             edge_ok;
  wire             count_ok;
  wire [CNT_W-1:0] next_val;
  wire [CNT_W-1:0] th1;
  wire [CNT_W-1:0] th2;
  wire             relative;
  wire             repeat_mode;
  wire             hit_final;
  wire             pulse_stop;
  reg  [31:0]      rd_val;
  reg              rd_known;

  // ****************************************
  // Write decode
  // ****************************************
  // Only the low two byte lanes carry data; upper lanes are ignored
  assign wr_fire  = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign wr_mask  = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign ctrl_new = (ctrl_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);
  assign cfg_new  = (cfg_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);
  assign wr_ctrl  = wr_fire & (waddr_q == `RSC_OFF_CTRL);
  assign wr_cfg   = wr_fire & (waddr_q == `RSC_OFF_CFG);
  assign wr_known = (waddr_q == `RSC_OFF_CTRL) | (waddr_q == `RSC_OFF_SP1) |
                    (waddr_q == `RSC_OFF_SP2) | (waddr_q == `RSC_OFF_FINAL) |
                    (waddr_q == `RSC_OFF_WIDTH) | (waddr_q == `RSC_OFF_CFG);

  // Start only on a 0 to 1 write of the load bit; restart bit has no effect
  assign load_evt = wr_ctrl & ctrl_new[`RSC_CTRL_LOAD] &
                    ~ctrl_q[`RSC_CTRL_LOAD];

  // Mode, direction, kill behaviour or type altered by this write
  assign cfg_change =
    (wr_ctrl & (ctrl_new[`RSC_DIR_MSB:`RSC_MODE_LSB] !=
                ctrl_q[`RSC_DIR_MSB:`RSC_MODE_LSB])) |
    (wr_cfg & ((cfg_new[`RSC_CFG_TYPE_MSB:`RSC_CFG_TYPE_LSB] !=
                cfg_q[`RSC_CFG_TYPE_MSB:`RSC_CFG_TYPE_LSB]) |
               (cfg_new[`RSC_CFG_KILL_ASGN] != cfg_q[`RSC_CFG_KILL_ASGN])));

  // Forced switch-off from the control bit or the assigned kill input
  assign kill_now = ctrl_q[`RSC_CTRL_KILL] |
                    (cfg_q[`RSC_CFG_KILL_ASGN] & output_kill_input);

  // ****************************************
  // Count qualification and thresholds
  // ****************************************
  assign edge_ok  = cfg_q[`RSC_CFG_FALLING] ? (pulse_in_q & ~count_pulse_in) :
                                              (~pulse_in_q & count_pulse_in);
  // Unassigned enable means always enabled
  assign count_ok = running_q & edge_ok & ~kill_now &
                    (~cfg_q[`RSC_CFG_EN_ASSIGN] | count_enable_in);
  assign next_val = actual_q + {{(CNT_W-1){1'b0}}, 1'b1};
  assign relative = (cfg_q[`RSC_CFG_TYPE_MSB:`RSC_CFG_TYPE_LSB] == `RSC_TYPE_RELATIVE);
  assign th1      = relative ? (final_q[CNT_W-1:0] - sp1_q[CNT_W-1:0]) : sp1_q[CNT_W-1:0];
  assign th2      = relative ? (final_q[CNT_W-1:0] - sp2_q[CNT_W-1:0]) : sp2_q[CNT_W-1:0];
  assign repeat_mode = (ctrl_q[`RSC_MODE_MSB:`RSC_MODE_LSB] == `RSC_MODE_REPEAT);
  assign hit_final   = count_ok & (next_val == final_q[CNT_W-1:0]);
  assign pulse_stop  = kill_now | cfg_change | load_evt;

  // ****************************************
  // Register writes
  // ****************************************
  // The load bit is stored so a later 0 to 1 write can start again
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q  <= `RSC_RST_CTRL;
      cfg_q   <= `RSC_RST_CFG;
      sp1_q   <= `RSC_RST_SP1;
      sp2_q   <= `RSC_RST_SP2;
      final_q <= `RSC_RST_FINAL;
      width_q <= `RSC_RST_WIDTH;
    end
    else if (wr_fire)
    begin
      case (waddr_q)
        `RSC_OFF_CTRL:  ctrl_q  <= ctrl_new;
        `RSC_OFF_CFG:   cfg_q   <= cfg_new;
        `RSC_OFF_SP1:   sp1_q   <= (sp1_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);
        `RSC_OFF_SP2:   sp2_q   <= (sp2_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);
        `RSC_OFF_FINAL: final_q <= (final_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);
        `RSC_OFF_WIDTH: width_q <= (width_q & ~wr_mask) | (wdata_q[15:0] & wr_mask);
        default:        ctrl_q  <= ctrl_q;
      endcase
    end
  end

  // ****************************************
  // Counter and set-point outputs
  // ****************************************
  // Priority: switch-off, then settings change, then start, then counting.
  // The load/start input pin is deliberately not looked at here.
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      actual_q            <= {CNT_W{1'b0}};
      running_q           <= 1'b0;
      pulse_in_q          <= 1'b0;
      setpoint_one_output <= 1'b0;
      setpoint_two_output <= 1'b0;
      final_point_output  <= 1'b0;
    end
    else
    begin
      pulse_in_q <= count_pulse_in;
      if (kill_now)
      begin
        running_q           <= 1'b0;
        setpoint_one_output <= 1'b0;
        setpoint_two_output <= 1'b0;
        final_point_output  <= 1'b0;
      end
      else if (cfg_change)
      begin
        running_q           <= 1'b0;
        setpoint_one_output <= 1'b0;
        setpoint_two_output <= 1'b0;
        final_point_output  <= 1'b0;
      end
      else if (load_evt)
      begin
        actual_q            <= {CNT_W{1'b0}};
        running_q           <= 1'b1;
        setpoint_one_output <= 1'b1;
        setpoint_two_output <= 1'b1;
        final_point_output  <= 1'b0;
      end
      else if (hit_final)
      begin
        final_point_output  <= 1'b0;
        setpoint_one_output <= 1'b1;
        setpoint_two_output <= 1'b0;
        // Non-repetitive modes hold at the final value and stop
        if (repeat_mode)
          actual_q <= {CNT_W{1'b0}};
        else
        begin
          actual_q  <= next_val;
          running_q <= 1'b0;
        end
      end
      else if (count_ok)
      begin
        actual_q <= next_val;
        if (next_val == th1)
        begin
          setpoint_one_output <= 1'b0;
          setpoint_two_output <= 1'b1;
        end
        if (next_val == th2)
        begin
          setpoint_two_output <= 1'b0;
          final_point_output  <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Timed final set-point pulse
  // ****************************************
  rsc_pulse_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .WIDTH_W     (16)
  ) u_pulse (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (hit_final & ~pulse_stop),
    .stop    (pulse_stop),
    .width   (width_q),
    .pulse_q (timed_final_pulse_output)
  );

  // ****************************************
  // AXI write channel
  // ****************************************
  // Address and data are caught independently; response after both
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      waddr_q       <= 6'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RSC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_got_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_got_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_got_q      <= 1'b1;
        waddr_q       <= {s_axi_awaddr[5:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_got_q      <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Status words mirror the live set-point and final outputs, not the timed pulse; reads have no side effects
  always @*
  begin
    rd_val   = 32'h00000000;
    rd_known = 1'b1;
    case ({s_axi_araddr[5:2], 2'b00})
      `RSC_OFF_CTRL:   rd_val[15:0] = ctrl_q;
      `RSC_OFF_STAT_A:
      begin
        rd_val[`RSC_STA_SP1] = setpoint_one_output;
        rd_val[`RSC_STA_SP2] = setpoint_two_output;
      end
      `RSC_OFF_STAT_B: rd_val[`RSC_STB_FINAL] = final_point_output;
      `RSC_OFF_ACTUAL: rd_val[CNT_W-1:0] = actual_q;
      `RSC_OFF_SP1:    rd_val[15:0] = sp1_q;
      `RSC_OFF_SP2:    rd_val[15:0] = sp2_q;
      `RSC_OFF_FINAL:  rd_val[15:0] = final_q;
      `RSC_OFF_WIDTH:  rd_val[15:0] = width_q;
      `RSC_OFF_CFG:    rd_val[15:0] = cfg_q;
      default:         rd_known = 1'b0;
    endcase
  end

  // ****************************************
  // AXI read channel
  // ****************************************
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RSC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_known ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> test/rsc_top_assertions.sv
// Port checker for the set-point counter channel, bound into rsc_top.
// Assumes default set points (11, 5, final 30) and one AXI write at a time.
`timescale 1ns/10ps
`include "rsc_consts.vh"

module rsc_top_assertions #(
  parameter TICK_CYCLES = 4,
  parameter CNT_W       = 16
) (
  input wire        clock,
  input wire        reset_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [5:0]  s_axi_awaddr,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_bvalid,
  input wire [1:0]  s_axi_bresp,
  input wire        count_pulse_in,
  input wire        output_kill_input,
  input wire        setpoint_one_output,
  input wire        setpoint_two_output,
  input wire        final_point_output,
  input wire        timed_final_pulse_output
);
  logic        bv_q, pin_q, run_q;
  logic [5:0]  wa_q;
  logic [15:0] wd_q, ctl_q, cfg_q;
  logic [4:0]  edg_q;
  // Committed writes seen at the edge where the response appears
  wire cm  = s_axi_bvalid && !bv_q && (s_axi_bresp == `RSC_RESP_OKAY);
  wire cc  = cm && (wa_q == `RSC_OFF_CTRL);
  wire cf  = cm && (wa_q == `RSC_OFF_CFG);
  wire chg = (cc && (wd_q[11:4] != ctl_q[11:4]))
          || (cf && ({wd_q[5], wd_q[3:0]} != {cfg_q[5], cfg_q[3:0]}));
  wire ld  = cc && wd_q[0] && !ctl_q[0] && !wd_q[2] && !chg;
  wire kin = cfg_q[5] && output_kill_input;
  wire off = !(setpoint_one_output || setpoint_two_output || final_point_output
            || timed_final_pulse_output);
  wire hit = count_pulse_in && !pin_q && run_q;

  // Shadow registers; edge count wraps at the default final value only
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bv_q  <= 1'b0;
      pin_q <= 1'b0;
      run_q <= 1'b0;
      wa_q  <= 6'h00;
      wd_q  <= 16'h0000;
      ctl_q <= `RSC_RST_CTRL;
      cfg_q <= `RSC_RST_CFG;
      edg_q <= 5'h00;
    end
    else
    begin
      bv_q  <= s_axi_bvalid;
      pin_q <= count_pulse_in;
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[15:0];
      if (cc) ctl_q <= wd_q;
      if (cf) cfg_q <= wd_q;
      if (ld) run_q <= 1'b1;
      else if (chg || (cc && wd_q[2]) || kin) run_q <= 1'b0;
      if (ld) edg_q <= 5'h00;
      else if (hit) edg_q <= (edg_q == 5'h1D) ? 5'h00 : edg_q + 5'h01;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_load_start:
    assert property (ld && !kin |-> ##[1:2] setpoint_one_output && setpoint_two_output
      && !final_point_output) else $error("start state wrong");
  a_sp1_point:
    assert property (hit && edg_q == 5'h12 |-> ##[1:3] !setpoint_one_output
      && setpoint_two_output) else $error("first set point switch wrong");
  a_sp2_point:
    assert property (hit && edg_q == 5'h18 |-> ##[1:3] !setpoint_two_output
      && final_point_output) else $error("second set point switch wrong");
  a_wrap_point:
    assert property (hit && edg_q == 5'h1D |-> ##[1:3] setpoint_one_output
      && !final_point_output) else $error("final point switch wrong");
  a_pulse_start:
    assert property (hit && edg_q == 5'h1D |-> ##[1:4] timed_final_pulse_output)
    else $error("timed pulse missing");
  a_kill_input:
    assert property (kin [*3] |-> off) else $error("kill input left outputs on");
  a_kill_bit:
    assert property (ctl_q[2] [*2] |-> off) else $error("kill bit left outputs on");
  a_mode_change:
    assert property (chg |-> ##[1:2] off) else $error("mode change left outputs on");

  // Main scenarios
  c_wrap: cover property (hit && edg_q == 5'h1D);
  c_kill: cover property (kin);
  c_change: cover property (chg);
endmodule

bind rsc_top rsc_top_assertions #(.TICK_CYCLES(TICK_CYCLES), .CNT_W(CNT_W)) u_chk (
  .clock(clock), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bresp(s_axi_bresp), .count_pulse_in(count_pulse_in),
  .output_kill_input(output_kill_input), .setpoint_one_output(setpoint_one_output),
  .setpoint_two_output(setpoint_two_output), .final_point_output(final_point_output),
  .timed_final_pulse_output(timed_final_pulse_output));

// >>> test/rsc_pulse_src.sv
// External pulse source model for the counting input.
// Assumes a one-cycle start request while idle; levels last one or three cycles.
`timescale 1ns/10ps

module rsc_pulse_src (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic [7:0] count,
  input  wire logic       slow,
  output logic            pulse_q,
  output logic            busy
);
  logic [7:0] left_q;
  logic [1:0] ph_q;
  assign busy = (left_q != 8'h00);

  // Each level held at least one clock so every edge is qualified
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      left_q  <= 8'h00;
      ph_q    <= 2'h0;
      pulse_q <= 1'b0;
    end
    else if (start && !busy)
      left_q <= count;
    else if (busy)
    begin
      if (ph_q != (slow ? 2'h2 : 2'h0))
        ph_q <= ph_q + 2'h1;
      else
      begin
        ph_q    <= 2'h0;
        pulse_q <= !pulse_q;
        if (pulse_q) left_q <= left_q - 8'h01;
      end
    end
  end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the set-point counter channel.
// Assumes rsc_top, the pulse source model and the bound port checker.
`timescale 1ns/10ps
`include "rsc_consts.vh"

module testbench;
  typedef struct { int n; logic [15:0] a; logic [3:0] e; logic [3:0] m; } rsc_row_t;
  logic        clock, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, o1, o2, o3, o4;
  logic        pulse, ps_go, ps_slow, ps_busy, ls_in, kill_in, en_in;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  ps_n;
  int          err_count, n_tests, i, t, w;
  rsc_row_t    rows [7];
  logic [5:0]  ra [6] = '{`RSC_OFF_CTRL, `RSC_OFF_CFG, `RSC_OFF_SP1, `RSC_OFF_SP2,
                          `RSC_OFF_FINAL, `RSC_OFF_WIDTH};
  logic [15:0] rv [6] = '{`RSC_RST_CTRL, `RSC_RST_CFG, `RSC_RST_SP1, `RSC_RST_SP2,
                          `RSC_RST_FINAL, `RSC_RST_WIDTH};

  // Short tick keeps the timed pulse to width*4 cycles
  rsc_top #(.TICK_CYCLES(4)) uut (.clock(clock), .reset_n(reset_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .count_pulse_in(pulse), .count_enable_in(en_in),
    .load_start_input(ls_in), .output_kill_input(kill_in), .setpoint_one_output(o1),
    .setpoint_two_output(o2), .final_point_output(o3), .timed_final_pulse_output(o4));
  rsc_pulse_src ps (.clock(clock), .reset_n(reset_n), .start(ps_go), .count(ps_n),
    .slow(ps_slow), .pulse_q(pulse), .busy(ps_busy));

  // Clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    #2000000;
    err_count++;
    print_verdict;
  end

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // AXI write: address and data offered together, bready held until bvalid
  task wr(input logic [5:0] a, input logic [15:0] v, input logic [1:0] er);
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= {16'h0000, v};
    bready  <= 1'b1;
    // No assumed latency: only the watchdog ends a stuck wait
    do
    begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task rd(input logic [5:0] a);
    @(posedge clock);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // The source only sees start one edge late, so busy is looked at after that
  task pulses(input logic [7:0] n);
    @(posedge clock);
    ps_go <= 1'b1;
    ps_n  <= n;
    @(posedge clock);
    ps_go <= 1'b0;
    @(posedge clock);
    for (t = 0; t < 400 && ps_busy === 1'b1; t++) @(posedge clock);
  endtask

  task chk_st(input logic [15:0] a, input logic [3:0] e, input logic [3:0] m);
    @(posedge clock);
    chk("outputs", {28'h0, e & m}, {28'h0, {o4, o3, o2, o1} & m});
    rd(`RSC_OFF_ACTUAL);
    chk("actual", {16'h0, a}, d);
    rd(`RSC_OFF_STAT_A);
    chk("status_a", {30'h0, e[1:0] & m[1:0]}, {30'h0, {d[9], d[1]} & m[1:0]});
    rd(`RSC_OFF_STAT_B);
    chk("status_b", {31'h0, e[2] & m[2]}, {31'h0, d[9] & m[2]});
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, ps_go, ps_slow, ls_in, kill_in, en_in} = 10'h000;
    {awaddr, araddr, wdata, ps_n, err_count, n_tests} = '0;
    rows = '{'{18, 16'h0012, 4'h3, 4'hF}, '{1, 16'h0013, 4'h2, 4'hF},
             '{5, 16'h0018, 4'h2, 4'hF}, '{1, 16'h0019, 4'h4, 4'hF},
             '{4, 16'h001D, 4'h4, 4'hF}, '{1, 16'h0000, 4'h9, 4'hD},
             '{19, 16'h0013, 4'h2, 4'h7}};
    reset_n = 1'b0;
    repeat (6) @(posedge clock);
    chk("reset outputs", 32'h0, {28'h0, o4, o3, o2, o1});
    reset_n <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      rd(ra[i]);
      chk("reset value", {16'h0, rv[i]}, d);
    end
    rd(6'h24);
    chk("unmapped resp", {30'h0, `RSC_RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    wr(`RSC_OFF_ACTUAL, 16'h1234, `RSC_RESP_SLVERR);
    wr(`RSC_OFF_CTRL, 16'h0051, `RSC_RESP_OKAY);
    chk_st(16'h0000, 4'h3, 4'hF);
    for (i = 0; i < 7; i++)
    begin
      pulses(rows[i].n[7:0]);
      chk_st(rows[i].a, rows[i].e, rows[i].m);
    end
    // A start level and a restart edge while counting change nothing
    ls_in   <= 1'b1;
    ps_slow <= 1'b1;
    pulses(8'h03);
    ls_in   <= 1'b0;
    ps_slow <= 1'b0;
    chk_st(16'h0016, 4'h2, 4'h7);
    wr(`RSC_OFF_CTRL, 16'h0053, `RSC_RESP_OKAY);
    chk_st(16'h0016, 4'h2, 4'h7);
    // Narrow timed pulse: count its high cycles around the wrap
    wr(`RSC_OFF_WIDTH, 16'h0002, `RSC_RESP_OKAY);
    pulses(8'h07);
    ps_go <= 1'b1;
    ps_n  <= 8'h01;
    @(posedge clock);
    ps_go <= 1'b0;
    w = 0;
    repeat (40)
    begin
      @(posedge clock);
      if (o4 === 1'b1) w++;
    end
    chk("pulse width", 32'd8, w);
    wr(`RSC_OFF_CTRL, 16'h0054, `RSC_RESP_OKAY);
    pulses(8'h02);
    chk_st(16'h0000, 4'h0, 4'hF);
    wr(`RSC_OFF_CTRL, 16'h0050, `RSC_RESP_OKAY);
    wr(`RSC_OFF_CTRL, 16'h0051, `RSC_RESP_OKAY);
    chk_st(16'h0000, 4'h3, 4'hF);
    wr(`RSC_OFF_CTRL, 16'h0041, `RSC_RESP_OKAY);
    chk_st(16'h0000, 4'h0, 4'hF);
    wr(`RSC_OFF_CTRL, 16'h0050, `RSC_RESP_OKAY);
    wr(`RSC_OFF_CFG, 16'h0021, `RSC_RESP_OKAY);
    wr(`RSC_OFF_CTRL, 16'h0051, `RSC_RESP_OKAY);
    chk_st(16'h0000, 4'h3, 4'hF);
    kill_in <= 1'b1;
    pulses(8'h02);
    chk_st(16'h0000, 4'h0, 4'hF);
    kill_in <= 1'b0;
    // Assigned enable input and falling-edge counting
    wr(`RSC_OFF_CFG, 16'h0051, `RSC_RESP_OKAY);
    wr(`RSC_OFF_CTRL, 16'h0050, `RSC_RESP_OKAY);
    wr(`RSC_OFF_CTRL, 16'h0051, `RSC_RESP_OKAY);
    pulses(8'h02);
    chk_st(16'h0000, 4'h3, 4'hF);
    en_in <= 1'b1;
    pulses(8'h03);
    chk_st(16'h0003, 4'h3, 4'hF);
    en_in <= 1'b0;
    print_verdict;
  end
endmodule
